//--- inc/lbp_regs.svh
// Constants of the lock bit protection block: bit positions, defaults, windows
`ifndef LBP_REGS_SVH
`define LBP_REGS_SVH

`define LBP_BIT_BOOT_HI 5
`define LBP_BIT_BOOT_LO 4
`define LBP_BIT_APP_HI 3
`define LBP_BIT_APP_LO 2
`define LBP_BIT_MEM_HI 1
`define LBP_BIT_MEM_LO 0
`define LBP_LOCK_DEFAULT 8'hFF
`define LBP_SECTION_MASK 8'h3C
`define LBP_BOOT_MASK 8'h30
`define LBP_BLOCKED_DATA 8'hFF
`define LBP_STORE_WINDOW 3'h4
`define LBP_LOAD_WINDOW 3'h3

`endif

//--- inc/lbp_pkg.sv
// Types shared by the lock bit protection block
package lbp_pkg;

    // Lock pair value equals mode code: {hi, lo}
    typedef enum logic [1:0] {
        LBP_MODE1 = 2'b11,
        LBP_MODE2 = 2'b10,
        LBP_MODE3 = 2'b00,
        LBP_MODE4 = 2'b01
    } lbp_mode_type;

    // Programmer commands
    typedef enum logic [2:0] {
        LBP_CMD_ERASE = 3'h0,
        LBP_CMD_MEM_WRITE = 3'h1,
        LBP_CMD_MEM_READ = 3'h2,
        LBP_CMD_FUSE_WRITE = 3'h3,
        LBP_CMD_LOCK_WRITE = 3'h4,
        LBP_CMD_LOCK_READ = 3'h5
    } lbp_cmd_type;

    // Lock write window states
    typedef enum logic [1:0] {
        LBP_WIN_IDLE = 2'b00,
        LBP_WIN_ARMED = 2'b01
    } lbp_win_type;

    // Permissions derived from the lock byte
    typedef struct packed {
        logic mem_prog_ok;
        logic mem_verify_ok;
        logic fuse_wr_ok;
        logic boot_lock_wr_ok;
        logic app_wr_ok;
        logic app_rd_from_boot_ok;
        logic boot_wr_ok;
        logic boot_rd_from_app_ok;
        logic irq_ok;
    } lbp_perm_type;

    // Programmer request bundle
    typedef struct packed {
        logic valid;
        lbp_cmd_type cmd;
        logic [7:0] data;
    } lbp_prog_req_type;

endpackage

//--- core/lbp_decide.sv
// Combinational protection decision from the lock byte
`timescale 1ns/10ps
`default_nettype none
`include "lbp_regs.svh"

module lbp_decide (
    input wire logic [7:0] lock_byte,
    input wire logic exec_in_boot,
    input wire logic vectors_in_boot,
    output lbp_pkg::lbp_perm_type perm
);

    // Pair of lock bits to mode
    function automatic lbp_pkg::lbp_mode_type mode_of(input logic hi, input logic lo);
        mode_of = lbp_pkg::lbp_mode_type'({hi, lo});
    endfunction

    lbp_pkg::lbp_mode_type mem_mode;
    lbp_pkg::lbp_mode_type app_mode;
    lbp_pkg::lbp_mode_type boot_mode;
    logic app_rd_lock;
    logic boot_rd_lock;

    // Mode decode of the three pairs
    assign mem_mode = mode_of(lock_byte[`LBP_BIT_MEM_HI], lock_byte[`LBP_BIT_MEM_LO]);
    assign app_mode = mode_of(lock_byte[`LBP_BIT_APP_HI], lock_byte[`LBP_BIT_APP_LO]);
    assign boot_mode = mode_of(lock_byte[`LBP_BIT_BOOT_HI], lock_byte[`LBP_BIT_BOOT_LO]);
    assign app_rd_lock = (app_mode == lbp_pkg::LBP_MODE3) || (app_mode == lbp_pkg::LBP_MODE4);
    assign boot_rd_lock = (boot_mode == lbp_pkg::LBP_MODE3) || (boot_mode == lbp_pkg::LBP_MODE4);

    // Programmer side; memory lock mode 4 code is unused, treated as mode 3
    always_comb begin
        perm = '0;
        perm.mem_prog_ok = (mem_mode == lbp_pkg::LBP_MODE1);
        perm.mem_verify_ok = (mem_mode == lbp_pkg::LBP_MODE1)
            || (mem_mode == lbp_pkg::LBP_MODE2);
        perm.fuse_wr_ok = (mem_mode == lbp_pkg::LBP_MODE1);
        perm.boot_lock_wr_ok = perm.mem_verify_ok;
        // Section locks for self-programming
        perm.app_wr_ok = (app_mode == lbp_pkg::LBP_MODE1)
            || (app_mode == lbp_pkg::LBP_MODE4);
        perm.app_rd_from_boot_ok = !app_rd_lock;
        perm.boot_wr_ok = (boot_mode == lbp_pkg::LBP_MODE1)
            || (boot_mode == lbp_pkg::LBP_MODE4);
        perm.boot_rd_from_app_ok = !boot_rd_lock;
        // Interrupts follow the section of the vectors
        perm.irq_ok = !((app_rd_lock && vectors_in_boot && !exec_in_boot)
            || (boot_rd_lock && !vectors_in_boot && exec_in_boot));
    end

endmodule
`default_nettype wire

//--- core/lbp_top.sv
// Lock byte storage and access gating for programmer and self-programming
`timescale 1ns/10ps
`default_nettype none
`include "lbp_regs.svh"

module lbp_top #(
    parameter int ADDR_W = 18,
    parameter logic [17:0] BOOT_BASE_DEFAULT = 18'h3E000
) (
    input wire logic clk,
    input wire logic rst,
    // Programmer interface
    input wire lbp_pkg::lbp_prog_req_type prog_req,
    output logic prog_ack_q,
    output logic prog_ok_q,
    output logic prog_mem_we_q,
    output logic prog_fuse_we_q,
    output logic prog_erase_q,
    output logic [7:0] prog_rdata_q,
    // Core control register write: select and enable bits
    input wire logic ctrl_wr,
    input wire logic ctrl_lock_write_select,
    input wire logic ctrl_store_program_enable,
    // Core store and load program instructions
    input wire logic store_program_instr,
    input wire logic load_program_instr,
    input wire logic [ADDR_W-1:0] pointer,
    // Lock write data, fuse byte for readback and section map
    input wire logic [7:0] r0_data,
    input wire logic [7:0] fuse_low,
    input wire logic [ADDR_W-1:0] boot_base,
    // Where code runs and where the vectors sit, from the core
    input wire logic exec_in_boot,
    input wire logic vectors_in_boot,
    // Answers to the core
    output logic store_ok_q,
    output logic store_blocked_q,
    output logic load_ok_q,
    output logic load_sub_valid_q,
    output logic [7:0] load_sub_data_q,
    // Status levels
    output logic lock_write_select_q,
    output logic irq_allow_q,
    output logic [7:0] lock_byte_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Decision logic
    // All gating is static: no state beyond the stored byte and the lock write window feeds a decision

    lbp_pkg::lbp_perm_type perm;
    logic [7:0] lock_q;
    logic ptr_in_boot;

    // Target section of the current pointer
    // Everything at or above boot_base is boot loader, everything below application
    assign ptr_in_boot = (pointer >= boot_base);

    // Decision always reads the live lock byte
    // Combinational, so a lock bit written at one edge governs the next access
    lbp_decide u_decide (
        .lock_byte(lock_q),
        .exec_in_boot(exec_in_boot),
        .vectors_in_boot(vectors_in_boot),
        .perm(perm)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Lock write window after select plus enable
    // Four cycles for a lock store, three for a lock or fuse readback

    lbp_pkg::lbp_win_type win_q;
    logic [2:0] store_cnt_q;
    logic [2:0] load_cnt_q;
    logic arm;
    logic store_special;
    logic load_special;
    logic win_close;

    // Saturating count down, shared by the store and load windows
    function automatic logic [2:0] count_down(input logic [2:0] cnt);
        count_down = (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
    endfunction

    // Select and enable must come in one control write; either alone arms nothing
    assign arm = ctrl_wr && ctrl_lock_write_select && ctrl_store_program_enable;
    // Special accesses need the window open and their own count running
    assign store_special = (win_q == lbp_pkg::LBP_WIN_ARMED)
        && (store_cnt_q != 3'h0) && store_program_instr;
    assign load_special = (win_q == lbp_pkg::LBP_WIN_ARMED)
        && (load_cnt_q != 3'h0) && load_program_instr;

    // Window ends on its own store or after its last legal cycle
    assign win_close = store_special || (store_cnt_q <= 3'h1);

    // Window state; a store or timeout ends it
    // A re-arm inside the window restarts it rather than stacking a second one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_q <= lbp_pkg::LBP_WIN_IDLE;
        end else begin
            unique case (win_q)
                lbp_pkg::LBP_WIN_IDLE: begin
                    if (arm) begin
                        win_q <= lbp_pkg::LBP_WIN_ARMED;
                    end
                end
                lbp_pkg::LBP_WIN_ARMED: begin
                    if (arm) begin
                        win_q <= lbp_pkg::LBP_WIN_ARMED;
                    end else if (win_close) begin
                        win_q <= lbp_pkg::LBP_WIN_IDLE;
                    end
                end
            endcase
        end
    end

    // Cycle counters for the store and load windows
    // The load window is one cycle shorter, so it runs out before the store window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            store_cnt_q <= 3'h0;
            load_cnt_q <= 3'h0;
        end else if (arm) begin
            store_cnt_q <= `LBP_STORE_WINDOW;
            load_cnt_q <= `LBP_LOAD_WINDOW;
        end else begin
            store_cnt_q <= count_down(store_cnt_q);
            load_cnt_q <= count_down(load_cnt_q);
        end
    end

    // Select bit readback, cleared on use or timeout
    // Software polls this to see that its lock write has completed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_write_select_q <= 1'b0;
        end else if (arm) begin
            lock_write_select_q <= 1'b1;
        end else if (win_close) begin
            lock_write_select_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock byte storage
    // Bits 7:6 have no function but are stored and read back like the rest

    logic prog_erase_req;
    logic prog_lock_wr;
    logic [7:0] prog_lock_mask;

    // Programmer requests that touch the stored byte
    assign prog_erase_req = prog_req.valid && (prog_req.cmd == lbp_pkg::LBP_CMD_ERASE);
    assign prog_lock_wr = prog_req.valid && (prog_req.cmd == lbp_pkg::LBP_CMD_LOCK_WRITE);
    // Boot lock bits freeze in memory lock mode 3
    // Lock writes only AND in, so only this freeze needs a permission
    assign prog_lock_mask = perm.boot_lock_wr_ok ? 8'hFF : ~`LBP_BOOT_MASK;

    // Only erase sets bits; all writes AND in so bits only go 1 to 0.
    // Reset restores the erased image since the array itself sits outside.
    // Erase outranks any write in the same cycle; core writes reach bits 5:2 only.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_q <= `LBP_LOCK_DEFAULT;
        end else if (prog_erase_req) begin
            lock_q <= `LBP_LOCK_DEFAULT;
        end else if (prog_lock_wr) begin
            lock_q <= lock_q & (prog_req.data | ~prog_lock_mask);
        end else if (store_special) begin
            lock_q <= lock_q & (r0_data | ~`LBP_SECTION_MASK);
        end
    end

    // Status copy of the byte
    // One cycle behind the stored byte; decisions never wait for it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_byte_q <= `LBP_LOCK_DEFAULT;
        end else begin
            lock_byte_q <= lock_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Programmer answers, one cycle after the request
    // Requests come as single-cycle pulses; back to back is fine

    logic prog_allowed;

    // Per-command permission
    // Erase and lock access stay open in every mode; erase is the only way back
    always_comb begin
        prog_allowed = 1'b1;
        unique case (prog_req.cmd)
            lbp_pkg::LBP_CMD_ERASE: prog_allowed = 1'b1;
            lbp_pkg::LBP_CMD_MEM_WRITE: prog_allowed = perm.mem_prog_ok;
            lbp_pkg::LBP_CMD_MEM_READ: prog_allowed = perm.mem_verify_ok;
            lbp_pkg::LBP_CMD_FUSE_WRITE: prog_allowed = perm.fuse_wr_ok;
            lbp_pkg::LBP_CMD_LOCK_WRITE: prog_allowed = 1'b1;
            lbp_pkg::LBP_CMD_LOCK_READ: prog_allowed = 1'b1;
            default: prog_allowed = 1'b0;
        endcase
    end

    // Strobes go out only when allowed; refused writes vanish
    // Refused commands still get an acknowledge, so the programmer never stalls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_ack_q <= 1'b0;
            prog_ok_q <= 1'b0;
            prog_mem_we_q <= 1'b0;
            prog_fuse_we_q <= 1'b0;
            prog_erase_q <= 1'b0;
        end else begin
            prog_ack_q <= prog_req.valid;
            prog_ok_q <= prog_req.valid && prog_allowed;
            prog_mem_we_q <= prog_req.valid && prog_allowed
                && (prog_req.cmd == lbp_pkg::LBP_CMD_MEM_WRITE);
            prog_fuse_we_q <= prog_req.valid && prog_allowed
                && (prog_req.cmd == lbp_pkg::LBP_CMD_FUSE_WRITE);
            prog_erase_q <= prog_erase_req;
        end
    end

    // Read data: lock byte for a lock read, filler for any verify, allowed or refused
    // Filler also stands for commands that return nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_rdata_q <= `LBP_BLOCKED_DATA;
        end else if (prog_req.valid) begin
            if (prog_req.cmd == lbp_pkg::LBP_CMD_LOCK_READ) begin
                prog_rdata_q <= lock_q;
            end else begin
                prog_rdata_q <= `LBP_BLOCKED_DATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-programming answers, one cycle after the instruction
    // Memory access itself happens outside; this block only grants or refuses

    logic store_allowed;
    logic load_allowed;
    logic store_plain;
    logic load_blocked;

    // Writes guarded by the target section's lock
    assign store_allowed = ptr_in_boot ? perm.boot_wr_ok : perm.app_wr_ok;
    // Reads across sections guarded; own-section reads always pass
    assign load_allowed = ptr_in_boot
        ? (exec_in_boot || perm.boot_rd_from_app_ok)
        : (!exec_in_boot || perm.app_rd_from_boot_ok);

    // A store inside the lock window is a lock write, not a memory store
    assign store_plain = store_program_instr && !store_special;
    // Blocked ordinary reads get filler in place of memory data
    assign load_blocked = load_program_instr && !load_special && !load_allowed;

    // Store results; a lock write is handled above
    // Exactly one of the two pulses answers each ordinary store
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            store_ok_q <= 1'b0;
            store_blocked_q <= 1'b0;
        end else begin
            store_ok_q <= store_plain && store_allowed;
            store_blocked_q <= store_plain && !store_allowed;
        end
    end

    // Load results and substitute data
    // Substitute data holds until the next substitute replaces it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_ok_q <= 1'b0;
            load_sub_valid_q <= 1'b0;
            load_sub_data_q <= `LBP_BLOCKED_DATA;
        end else begin
            load_ok_q <= load_program_instr && !load_special && load_allowed;
            load_sub_valid_q <= load_special || load_blocked;
            if (load_special) begin
                load_sub_data_q <= pointer[0] ? lock_q : fuse_low;
            end else if (load_blocked) begin
                load_sub_data_q <= `LBP_BLOCKED_DATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt gate

    // Registered gate; a lock change or a move between sections shows one cycle later.
    // The core must not rely on it for the instruction that crosses the boundary.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_allow_q <= 1'b1;
        end else begin
            irq_allow_q <= perm.irq_ok;
        end
    end

endmodule
`default_nettype wire

//--- verif/lbp_monitor.sv
// Checker of the lock bit protection top, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module lbp_monitor #(
    parameter int ADDR_W = 18
) (
    input wire logic clk,
    input wire logic rst,
    input wire lbp_pkg::lbp_prog_req_type prog_req,
    input wire logic prog_ack_q,
    input wire logic prog_ok_q,
    input wire logic prog_mem_we_q,
    input wire logic prog_fuse_we_q,
    input wire logic prog_erase_q,
    input wire logic [7:0] prog_rdata_q,
    input wire logic store_program_instr,
    input wire logic load_program_instr,
    input wire logic [ADDR_W-1:0] pointer,
    input wire logic [ADDR_W-1:0] boot_base,
    input wire logic exec_in_boot,
    input wire logic vectors_in_boot,
    input wire logic store_ok_q,
    input wire logic store_blocked_q,
    input wire logic load_sub_valid_q,
    input wire logic [7:0] load_sub_data_q,
    input wire logic lock_write_select_q,
    input wire logic irq_allow_q,
    input wire logic [7:0] lock_byte_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Application code running while boot vectors and app modes 3/4 apply
    sequence s_app_irq;
        !exec_in_boot && vectors_in_boot && !lock_byte_q[3] && !prog_erase_q;
    endsequence
    ////////////////////////////////////////
    a_ack_next: assert property (prog_req.valid |=> prog_ack_q)
        else $error("programmer request not answered");
    a_only_clears: assert property ((lock_byte_q & ~$past(lock_byte_q)) != 8'h00
        |-> $past(prog_erase_q)) else $error("lock bit set without erase");
    a_mem_we_mode: assert property (prog_mem_we_q |-> lock_byte_q[1:0] == 2'b11)
        else $error("memory write strobe under memory lock");
    a_fuse_we_mode: assert property (prog_fuse_we_q |-> lock_byte_q[1:0] == 2'b11)
        else $error("fuse write strobe under memory lock");
    a_verify_mode: assert property (prog_ack_q && prog_ok_q &&
        $past(prog_req.cmd) == lbp_pkg::LBP_CMD_MEM_READ |-> lock_byte_q[1] == 1'b1)
        else $error("verify permitted in memory lock mode 3");
    a_refused_data: assert property (prog_ack_q && !prog_ok_q |-> prog_rdata_q == 8'hFF)
        else $error("refused command exposes data");
    a_app_write: assert property (store_program_instr && pointer < boot_base
        && !lock_byte_q[2] && !prog_erase_q |=> !store_ok_q)
        else $error("app write let through");
    a_boot_write: assert property (store_program_instr && pointer >= boot_base
        && !lock_byte_q[4] && !prog_erase_q |=> !store_ok_q)
        else $error("boot write let through");
    a_boot_read: assert property (load_program_instr && !exec_in_boot &&
        pointer >= boot_base && !lock_byte_q[5] && !lock_write_select_q && !prog_erase_q
        |=> load_sub_valid_q && load_sub_data_q == 8'hFF) else $error("boot read let through");
    a_irq_off: assert property (s_app_irq ##1 s_app_irq |=> !irq_allow_q)
        else $error("interrupt allowed in locked application");
    a_window_ends: assert property ($rose(lock_write_select_q)
        |-> ##[1:4] !lock_write_select_q) else $error("lock window never closes");
    // Main scenarios
    c_lock_write: cover property ($fell(lock_write_select_q));
    c_store_blocked: cover property (store_blocked_q);
    c_load_sub: cover property (load_sub_valid_q);
endmodule
bind lbp_top lbp_monitor #(.ADDR_W(ADDR_W)) u_lbp_monitor (.clk, .rst, .prog_req,
    .prog_ack_q, .prog_ok_q, .prog_mem_we_q, .prog_fuse_we_q, .prog_erase_q,
    .prog_rdata_q, .store_program_instr, .load_program_instr, .pointer, .boot_base,
    .exec_in_boot, .vectors_in_boot, .store_ok_q, .store_blocked_q, .load_sub_valid_q,
    .load_sub_data_q, .lock_write_select_q, .irq_allow_q, .lock_byte_q);
`default_nettype wire

//--- verif/lbp_prog_model.sv
// Programmer model issuing one command pulse at a time
`timescale 1ns/10ps
`default_nettype none
module lbp_prog_model (
    input wire logic clk,
    output var lbp_pkg::lbp_prog_req_type prog_req
);
    initial prog_req = '{valid: 1'b0, cmd: lbp_pkg::LBP_CMD_LOCK_READ, data: 8'h00};
    // Idle data is flipped so a stale byte never looks like a command
    task automatic send(input lbp_pkg::lbp_cmd_type cmd, input logic [7:0] data);
        @(negedge clk);
        prog_req.valid = 1'b1;
        prog_req.cmd = cmd;
        prog_req.data = data;
        @(negedge clk);
        prog_req.valid = 1'b0;
        prog_req.data = ~data;
    endtask
endmodule
`default_nettype wire

//--- verif/lock_bit_protection_tb.sv
// Self-checking bench of the lock bit protection block
`timescale 1ns/10ps
`default_nettype none
module lock_bit_protection_tb;
    localparam logic [17:0] PA = 18'h00100;
    localparam logic [17:0] PB = 18'h3E100;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic st = 1'b0;
    logic ld = 1'b0;
    logic in_boot = 1'b0;
    logic vec_boot = 1'b0;
    logic en = 1'b1;
    logic [17:0] ptr = 18'h00000;
    logic [7:0] r0 = 8'hFF;
    logic [7:0] fuse = 8'hFF;
    logic [7:0] lk;
    logic [1:0] m;
    lbp_pkg::lbp_prog_req_type prog_req;
    logic ack, ok, mwe, fwe, ers, sok, sbl, lok, lsv, sel, irq;
    logic [7:0] rdata, sdata, lock_q;
    logic [11:0] pq[$];
    logic [11:0] cq[$];
    logic [11:0] e;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    lbp_prog_model u_lbp_prog_model (.clk(clk), .prog_req(prog_req));
    lbp_top u_lbp_top (.clk(clk), .rst(rst), .prog_req(prog_req), .prog_ack_q(ack),
        .prog_ok_q(ok), .prog_mem_we_q(mwe), .prog_fuse_we_q(fwe), .prog_erase_q(ers),
        .prog_rdata_q(rdata), .ctrl_wr(wr), .ctrl_lock_write_select(wr),
        .ctrl_store_program_enable(wr & en), .store_program_instr(st),
        .load_program_instr(ld), .pointer(ptr), .r0_data(r0), .fuse_low(fuse),
        .boot_base(18'h3E000), .exec_in_boot(in_boot), .vectors_in_boot(vec_boot),
        .store_ok_q(sok), .store_blocked_q(sbl), .load_ok_q(lok), .load_sub_valid_q(lsv),
        .load_sub_data_q(sdata), .lock_write_select_q(sel), .irq_allow_q(irq),
        .lock_byte_q(lock_q));
    always #4 clk = ~clk;
    ////////////////////////////////////////
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Store and load notes: allowed, or blocked with filler data
    function automatic logic [11:0] se(input logic k);
        return {k, ~k, 10'h0FF};
    endfunction
    function automatic logic [11:0] le(input logic k);
        return {2'b00, k, ~k, 8'hFF};
    endfunction
    task automatic prog(input lbp_pkg::lbp_cmd_type c, input logic [7:0] d,
        input logic [11:0] x);
        pq.push_back(x);
        u_lbp_prog_model.send(c, d);
    endtask
    // Core side: all strobes change together at the falling edge
    task automatic core(input logic w, s, l, b, input logic [17:0] p, input logic [11:0] x);
        @(negedge clk);
        wr = w;
        st = s;
        ld = l;
        in_boot = b;
        ptr = p;
        if ((s | l) && x != 12'h000) cq.push_back(x);
    endtask
    // Oldest note is compared once the edge's updates have landed
    always @(posedge clk) begin
        #1;
        if (ack === 1'b1) begin
            e = (pq.size() != 0) ? pq.pop_front() : 12'hXXX;
            check({ok, mwe, fwe, ers, rdata}, e);
        end
        if ((sok | sbl | lok | lsv) === 1'b1) begin
            e = (cq.size() != 0) ? cq.pop_front() : 12'hXXX;
            check({sok, sbl, lok, lsv, (lsv === 1'b1) ? sdata : 8'hFF}, e);
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        r0 = 8'($urandom(32'h321E46F1));
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check({4'h0, lock_q}, 12'h0FF);
        check({11'h000, irq}, 12'h001);
        // Every section lock mode, set alike in both sections
        for (int i = 0; i < 4; i++) begin
            m = 2'(i ^ 3);
            lk = {2'b11, m, m, 2'b11};
            prog(lbp_pkg::LBP_CMD_ERASE, 8'hFF, 12'h9FF);
            prog(lbp_pkg::LBP_CMD_LOCK_WRITE, lk, 12'h8FF);
            prog(lbp_pkg::LBP_CMD_LOCK_READ, 8'hFF, {4'h8, lk});
            core(0, 1, 0, 1, PA, se(m[0]));
            core(0, 1, 0, 0, PB, se(m[0]));
            core(0, 0, 1, 1, PA, le(m[1]));
            core(0, 0, 1, 0, PB, le(m[1]));
            core(0, 0, 1, 1, PB, le(1'b1));
            vec_boot = 1'b1;
            repeat (2) core(0, 0, 0, 0, PA, 12'h000);
            check({11'h000, irq}, {11'h000, m[1]});
            vec_boot = 1'b0;
            repeat (2) core(0, 0, 0, 1, PA, 12'h000);
            check({11'h000, irq}, {11'h000, m[1]});
        end
        // Memory lock modes, section locks already settled
        prog(lbp_pkg::LBP_CMD_ERASE, 8'hFF, 12'h9FF);
        prog(lbp_pkg::LBP_CMD_MEM_WRITE, 8'h5A, 12'hCFF);
        prog(lbp_pkg::LBP_CMD_FUSE_WRITE, 8'h5A, 12'hAFF);
        prog(lbp_pkg::LBP_CMD_LOCK_WRITE, 8'hFE, 12'h8FF);
        prog(lbp_pkg::LBP_CMD_MEM_WRITE, 8'h5A, 12'h0FF);
        prog(lbp_pkg::LBP_CMD_FUSE_WRITE, 8'h5A, 12'h0FF);
        prog(lbp_pkg::LBP_CMD_MEM_READ, 8'h00, 12'h8FF);
        prog(lbp_pkg::LBP_CMD_LOCK_WRITE, 8'hFC, 12'h8FF);
        prog(lbp_pkg::LBP_CMD_MEM_READ, 8'h00, 12'h0FF);
        prog(lbp_pkg::LBP_CMD_MEM_WRITE, 8'h00, 12'h0FF);
        prog(lbp_pkg::LBP_CMD_LOCK_WRITE, 8'hC0, 12'h8FF);
        prog(lbp_pkg::LBP_CMD_LOCK_READ, 8'hFF, 12'h8F0);
        prog(lbp_pkg::LBP_CMD_LOCK_WRITE, 8'hFF, 12'h8FF);
        prog(lbp_pkg::LBP_CMD_LOCK_READ, 8'hFF, 12'h8F0);
        // Core lock write with special reads inside the window
        prog(lbp_pkg::LBP_CMD_ERASE, 8'hFF, 12'h9FF);
        r0 = 8'($urandom);
        fuse = 8'($urandom);
        core(1, 0, 0, 1, PB, 12'h000);
        core(0, 0, 1, 1, PB | 18'h00001, 12'h1FF);
        check({11'h000, sel}, 12'h001);
        core(0, 0, 1, 1, PB, {4'h1, fuse});
        core(0, 1, 0, 1, PA, 12'h000);
        core(0, 0, 0, 1, PA, 12'h000);
        check({11'h000, sel}, 12'h000);
        lk = r0 | 8'hC3;
        prog(lbp_pkg::LBP_CMD_LOCK_READ, 8'hFF, {4'h8, lk});
        // Select without enable arms nothing, so the store is ordinary
        en = 1'b0;
        core(1, 0, 0, 1, PA, 12'h000);
        core(0, 1, 0, 1, PA, se(lk[2]));
        en = 1'b1;
        // A store in the first cycle after the window is an ordinary store
        core(1, 0, 0, 1, PA, 12'h000);
        repeat (4) core(0, 0, 0, 1, PA, 12'h000);
        core(0, 1, 0, 1, PA, se(lk[2]));
        check({11'h000, sel}, 12'h000);
        core(0, 0, 0, 1, PA, 12'h000);
        repeat (4) @(posedge clk);
        check(12'(pq.size() + cq.size()), 12'h000);
        test_done();
    end
endmodule
`default_nettype wire
